// ### verilog/qet_timer.sv
// quadrature encoder timer: encoder counter, compare channels, ref clear,
// event flags and two interrupt vectors behind an 8-bit register port
// assumes one clock, and software that keeps the configuration rules
// Function
// R1: trigger high clears enabled channel's reference
// R2: cleared reference stays low until update
// R3: clearing ignored in forced output modes
// R4: software sets trigger prescale 00, mode2 off
// R5: slave mode selects B, A or both
// R6: per-input polarity bit and digital filter
// R7: encoder edges alone clock the running counter
// R8: direction updated on every input edge
// R9: counter wraps between zero and reload
// R10: software loads reload before enabling encoder
// R11: compare, prescaler, trigger output keep working
// R12: software never combines encoder and mode2
// R13: A-only counting by A edge, B level
// R14: B-only counting by B edge, A level
// R15: both-edge counting cancels single-input jitter
// R16: eight sources onto two interrupt vectors
// R17: update raised by overflow, underflow, reinit
// R18: request only when its enable bit set
// R19: event register raises each source by software
// R20: direction zero up, one down
// R21: direction read-only while encoder mode active
// R22: software avoids encoder with center-aligned
// R23: synchronised inputs, one count per edge
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module qet_timer import qet_pkg::*; (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire qet_bus_req_t bus_req,
   output logic [QET_DW-1:0] rd_data,
   input wire logic encoder_input_a,
   input wire logic encoder_input_b,
   input wire logic ext_trigger_pin,
   output logic [QET_NCH-1:0] channel_ref_wave,
   output logic dir_flag,
   output logic trig_out,
   output logic irq_main,
   output logic irq_capcomp
);
   logic counter_run_reg;
   logic dir_reg;
   logic [2:0] slave_mode_select_reg;
   logic [3:0] ext_trigger_filter_reg;
   logic [1:0] ext_trigger_prescale_reg;
   logic ext_clock_mode2_enable_reg;
   logic ext_trigger_polarity_reg;
   logic input_a_polarity_reg;
   logic input_b_polarity_reg;
   logic [3:0] input_filter_reg;
   logic [7:0] irq_enable_reg;
   logic [7:0] status_reg;
   logic [QET_CW-1:0] cnt_reg;
   logic [QET_CW-1:0] psc_reg;
   logic [QET_CW-1:0] psc_cnt_reg;
   logic [QET_CW-1:0] auto_reload_value_reg;
   logic [QET_CW-1:0] cmp_reg [QET_NCH];
   qet_chan_cfg_t chan_cfg_reg [QET_NCH];
   logic filtered_input_a;
   logic filtered_input_b;
   logic filtered_ext_trigger;
   logic a_prev_reg;
   logic b_prev_reg;
   logic trg_prev_reg;

   logic [QET_NCH-1:0] cc_event;
   logic [7:0] hw_event;
   logic [7:0] sw_event;
   logic enc_mode;
   logic edge_a;
   logic edge_b;
   logic enc_up;
   logic enc_tick;
   logic int_tick;
   logic tick;
   logic count_up;
   logic overflow;
   logic underflow;
   logic reinit;
   logic update_event;
   logic wr_hit;
   logic [QET_CW-1:0] cnt_next;

   // three pins share one synchroniser and filter design
   qet_in_filter #(.FW(QET_FILT_W)) u_filt_a (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin(encoder_input_a),
      .filt_len(input_filter_reg),
      .invert(input_a_polarity_reg),
      .level(filtered_input_a)
   ); // R6 R23
   qet_in_filter #(.FW(QET_FILT_W)) u_filt_b (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin(encoder_input_b),
      .filt_len(input_filter_reg),
      .invert(input_b_polarity_reg),
      .level(filtered_input_b)
   ); // R6 R23
   qet_in_filter #(.FW(QET_FILT_W)) u_filt_trg (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin(ext_trigger_pin),
      .filt_len(ext_trigger_filter_reg),
      .invert(ext_trigger_polarity_reg),
      .level(filtered_ext_trigger)
   );

   assign wr_hit = bus_req.wr;
   assign sw_event = (wr_hit && bus_req.addr == QET_OFS_EVGEN) ? bus_req.wdata : QET_BYTE_RST; // R19

   // encoder edge decode
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         a_prev_reg <= 1'b0;
         b_prev_reg <= 1'b0;
         trg_prev_reg <= 1'b0;
      end else begin
         a_prev_reg <= filtered_input_a;
         b_prev_reg <= filtered_input_b;
         trg_prev_reg <= filtered_ext_trigger;
      end
   end

   assign enc_mode = (slave_mode_select_reg == QET_SLV_ENC_B) || (slave_mode_select_reg == QET_SLV_ENC_A) ||
                     (slave_mode_select_reg == QET_SLV_ENC_AB);
   assign edge_a = filtered_input_a ^ a_prev_reg;
   assign edge_b = filtered_input_b ^ b_prev_reg;

   // both inputs switching together is not a legal quadrature step
   always_comb begin
      enc_up = 1'b0;
      enc_tick = 1'b0;
      if (edge_a && !edge_b) begin
         enc_up = filtered_input_a ^ filtered_input_b; // R13 R15
         enc_tick = (slave_mode_select_reg == QET_SLV_ENC_A) || (slave_mode_select_reg == QET_SLV_ENC_AB); // R5
      end else if (edge_b && !edge_a) begin
         enc_up = ~(filtered_input_a ^ filtered_input_b); // R14 R15
         enc_tick = (slave_mode_select_reg == QET_SLV_ENC_B) || (slave_mode_select_reg == QET_SLV_ENC_AB); // R5
      end
   end

   assign int_tick = (slave_mode_select_reg == QET_SLV_INT) && (psc_cnt_reg == psc_reg);
   assign tick = counter_run_reg && (enc_mode ? enc_tick : int_tick); // R7
   assign count_up = enc_mode ? enc_up : ~dir_reg;
   assign overflow = tick && count_up && (cnt_reg == auto_reload_value_reg); // R9
   assign underflow = tick && !count_up && (cnt_reg == QET_WORD_RST); // R9
   assign reinit = sw_event[QET_EV_UPD];
   assign update_event = overflow || underflow || reinit; // R17

   // counter, one step per tick
   always_comb begin
      cnt_next = cnt_reg;
      if (reinit) begin
         cnt_next = dir_reg ? auto_reload_value_reg : QET_WORD_RST;
      end else if (overflow) begin
         cnt_next = QET_WORD_RST; // R9
      end else if (underflow) begin
         cnt_next = auto_reload_value_reg; // R9
      end else if (tick) begin
         cnt_next = count_up ? cnt_reg + QET_ONE : cnt_reg - QET_ONE; // R23
      end else if (wr_hit && bus_req.addr == QET_OFS_CNT_H) begin
         cnt_next = {bus_req.wdata, cnt_reg[7:0]};
      end else if (wr_hit && bus_req.addr == QET_OFS_CNT_L) begin
         cnt_next = {cnt_reg[15:8], bus_req.wdata};
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= QET_WORD_RST;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // prescaler keeps running whatever the counting source
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         psc_cnt_reg <= QET_WORD_RST;
      end else if (reinit || !counter_run_reg || psc_cnt_reg == psc_reg) begin
         psc_cnt_reg <= QET_WORD_RST; // R11
      end else begin
         psc_cnt_reg <= psc_cnt_reg + QET_ONE;
      end
   end

   // direction: hardware owns it in encoder mode
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dir_reg <= 1'b0;
      end else if (enc_mode) begin
         if (edge_a ^ edge_b) begin
            dir_reg <= ~enc_up; // R8 R20
         end
      end else if (wr_hit && bus_req.addr == QET_OFS_CTRL) begin
         dir_reg <= bus_req.wdata[QET_CTRL_DIR]; // R21
      end
   end

   // configuration registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         counter_run_reg <= 1'b0;
         slave_mode_select_reg <= QET_SLV_INT;
         ext_trigger_filter_reg <= '0;
         ext_trigger_prescale_reg <= '0;
         ext_clock_mode2_enable_reg <= 1'b0;
         ext_trigger_polarity_reg <= 1'b0;
         input_a_polarity_reg <= 1'b0;
         input_b_polarity_reg <= 1'b0;
         input_filter_reg <= '0;
         irq_enable_reg <= QET_BYTE_RST;
         psc_reg <= QET_WORD_RST;
         auto_reload_value_reg <= QET_RLD_RST;
      end else if (wr_hit) begin
         case (bus_req.addr)
            QET_OFS_CTRL: counter_run_reg <= bus_req.wdata[QET_CTRL_RUN];
            QET_OFS_SLAVE: slave_mode_select_reg <= bus_req.wdata[2:0];
            QET_OFS_ETCFG: begin
               ext_trigger_filter_reg <= bus_req.wdata[3:0];
               ext_trigger_prescale_reg <= bus_req.wdata[5:4];
               ext_clock_mode2_enable_reg <= bus_req.wdata[QET_ET_ECM2];
               ext_trigger_polarity_reg <= bus_req.wdata[QET_ET_POL];
            end
            QET_OFS_INCFG: begin
               input_a_polarity_reg <= bus_req.wdata[QET_IN_APOL]; // R6
               input_b_polarity_reg <= bus_req.wdata[QET_IN_BPOL]; // R6
               input_filter_reg <= bus_req.wdata[7:4];
            end
            QET_OFS_IRQEN: irq_enable_reg <= bus_req.wdata;
            QET_OFS_PSC_H: psc_reg <= {bus_req.wdata, psc_reg[7:0]};
            QET_OFS_PSC_L: psc_reg <= {psc_reg[15:8], bus_req.wdata};
            QET_OFS_RLD_H: auto_reload_value_reg <= {bus_req.wdata, auto_reload_value_reg[7:0]};
            QET_OFS_RLD_L: auto_reload_value_reg <= {auto_reload_value_reg[15:8], bus_req.wdata};
            default: ;
         endcase
      end
   end

   // compare channels with reference clear by external trigger
   genvar gi;
   generate
      for (gi = 0; gi < QET_NCH; gi++) begin : g_ch
         localparam logic [4:0] OFS_CFG = QET_OFS_CHCFG0 + 5'(gi);
         localparam logic [4:0] OFS_HI = QET_OFS_CMP0_H + 5'(2 * gi);
         localparam logic [4:0] OFS_LO = QET_OFS_CMP0_H + 5'(2 * gi + 1);
         logic match_prev_reg;
         logic ref_raw_reg;
         logic clr_hold_reg;
         logic match;
         logic forced;
         assign match = (cnt_reg == cmp_reg[gi]);
         assign forced = (chan_cfg_reg[gi].mode == QET_OC_FORCE_LO) || (chan_cfg_reg[gi].mode == QET_OC_FORCE_HI);
         assign cc_event[gi] = match && !match_prev_reg; // R11

         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               chan_cfg_reg[gi] <= '0;
               cmp_reg[gi] <= QET_WORD_RST;
            end else if (wr_hit && bus_req.addr == OFS_CFG) begin
               chan_cfg_reg[gi] <= {bus_req.wdata[QET_CH_CLREN], bus_req.wdata[2:0]}; // R1
            end else if (wr_hit && bus_req.addr == OFS_HI) begin
               cmp_reg[gi] <= {bus_req.wdata, cmp_reg[gi][7:0]};
            end else if (wr_hit && bus_req.addr == OFS_LO) begin
               cmp_reg[gi] <= {cmp_reg[gi][15:8], bus_req.wdata};
            end
         end

         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               match_prev_reg <= 1'b0;
               ref_raw_reg <= 1'b0;
            end else begin
               match_prev_reg <= match;
               case (chan_cfg_reg[gi].mode)
                  QET_OC_SET: ref_raw_reg <= ref_raw_reg | cc_event[gi];
                  QET_OC_CLR: ref_raw_reg <= ref_raw_reg & ~cc_event[gi];
                  QET_OC_TOGGLE: ref_raw_reg <= ref_raw_reg ^ cc_event[gi];
                  QET_OC_FORCE_LO: ref_raw_reg <= 1'b0;
                  QET_OC_FORCE_HI: ref_raw_reg <= 1'b1;
                  QET_OC_PWM1: ref_raw_reg <= (cnt_next < cmp_reg[gi]);
                  QET_OC_PWM2: ref_raw_reg <= !(cnt_next < cmp_reg[gi]);
                  default: ref_raw_reg <= ref_raw_reg;
               endcase
            end
         end

         // a trigger still high at the update re-arms the clear
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               clr_hold_reg <= 1'b0;
            end else if (chan_cfg_reg[gi].clear_en && filtered_ext_trigger && !forced) begin
               clr_hold_reg <= 1'b1; // R1 R3
            end else if (update_event || forced) begin
               clr_hold_reg <= 1'b0; // R2 R3
            end
         end

         assign channel_ref_wave[gi] = ref_raw_reg & ~(clr_hold_reg && !forced); // R1 R2 R3
      end
   endgenerate

   // event flags: hardware or software set wins over a clear
   assign hw_event = {1'b0, filtered_ext_trigger & ~trg_prev_reg, 1'b0, cc_event, overflow | underflow};
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         status_reg <= QET_BYTE_RST;
      end else if (wr_hit && bus_req.addr == QET_OFS_STATUS) begin
         status_reg <= (status_reg & bus_req.wdata) | hw_event | sw_event; // R19
      end else begin
         status_reg <= status_reg | hw_event | sw_event; // R16 R17 R19
      end
   end
   // update, trigger, commutation, break share one vector
   assign irq_main = |(status_reg & irq_enable_reg & 8'hE1); // R16 R18
   assign irq_capcomp = |(status_reg & irq_enable_reg & 8'h1E); // R16 R18
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         trig_out <= 1'b0;
      end else begin
         trig_out <= update_event; // R11
      end
   end
   assign dir_flag = dir_reg;

   // read port, data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_data <= QET_BYTE_RST;
      end else if (!bus_req.rd) begin
         rd_data <= QET_BYTE_RST;
      end else begin
         case (bus_req.addr)
            QET_OFS_CTRL: rd_data <= {3'h0, dir_reg, 3'h0, counter_run_reg}; // R21
            QET_OFS_SLAVE: rd_data <= {5'h00, slave_mode_select_reg};
            QET_OFS_ETCFG: rd_data <= {ext_trigger_polarity_reg, ext_clock_mode2_enable_reg,
                                       ext_trigger_prescale_reg, ext_trigger_filter_reg};
            QET_OFS_IRQEN: rd_data <= irq_enable_reg;
            QET_OFS_STATUS: rd_data <= status_reg;
            QET_OFS_INCFG: rd_data <= {input_filter_reg, 2'h0, input_b_polarity_reg, input_a_polarity_reg};
            QET_OFS_CNT_H: rd_data <= cnt_reg[15:8];
            QET_OFS_CNT_L: rd_data <= cnt_reg[7:0];
            QET_OFS_PSC_H: rd_data <= psc_reg[15:8];
            QET_OFS_PSC_L: rd_data <= psc_reg[7:0];
            QET_OFS_RLD_H: rd_data <= auto_reload_value_reg[15:8];
            QET_OFS_RLD_L: rd_data <= auto_reload_value_reg[7:0];
            5'h06: rd_data <= {chan_cfg_reg[0].clear_en, 4'h0, chan_cfg_reg[0].mode};
            5'h07: rd_data <= {chan_cfg_reg[1].clear_en, 4'h0, chan_cfg_reg[1].mode};
            5'h08: rd_data <= {chan_cfg_reg[2].clear_en, 4'h0, chan_cfg_reg[2].mode};
            5'h09: rd_data <= {chan_cfg_reg[3].clear_en, 4'h0, chan_cfg_reg[3].mode};
            5'h11: rd_data <= cmp_reg[0][15:8];
            5'h12: rd_data <= cmp_reg[0][7:0];
            5'h13: rd_data <= cmp_reg[1][15:8];
            5'h14: rd_data <= cmp_reg[1][7:0];
            5'h15: rd_data <= cmp_reg[2][15:8];
            5'h16: rd_data <= cmp_reg[2][7:0];
            5'h17: rd_data <= cmp_reg[3][15:8];
            5'h18: rd_data <= cmp_reg[3][7:0];
            default: rd_data <= QET_BYTE_RST;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### include/qet_pkg.sv
// quadrature encoder timer: shared constants, register map and carrier types
// assumes an 8-bit register port with a 5-bit byte address
package qet_pkg;
   localparam int QET_AW = 5;
   localparam int QET_DW = 8;
   localparam int QET_CW = 16;
   localparam int QET_NCH = 4;
   localparam int QET_FILT_W = 4;

   // register offsets
   localparam logic [4:0] QET_OFS_CTRL = 5'h00;
   localparam logic [4:0] QET_OFS_SLAVE = 5'h01;
   localparam logic [4:0] QET_OFS_ETCFG = 5'h02;
   localparam logic [4:0] QET_OFS_IRQEN = 5'h03;
   localparam logic [4:0] QET_OFS_STATUS = 5'h04;
   localparam logic [4:0] QET_OFS_EVGEN = 5'h05;
   localparam logic [4:0] QET_OFS_CHCFG0 = 5'h06;
   localparam logic [4:0] QET_OFS_INCFG = 5'h0A;
   localparam logic [4:0] QET_OFS_CNT_H = 5'h0B;
   localparam logic [4:0] QET_OFS_CNT_L = 5'h0C;
   localparam logic [4:0] QET_OFS_PSC_H = 5'h0D;
   localparam logic [4:0] QET_OFS_PSC_L = 5'h0E;
   localparam logic [4:0] QET_OFS_RLD_H = 5'h0F;
   localparam logic [4:0] QET_OFS_RLD_L = 5'h10;
   localparam logic [4:0] QET_OFS_CMP0_H = 5'h11;

   // field positions
   localparam int QET_CTRL_RUN = 0;
   localparam int QET_CTRL_DIR = 4;
   localparam int QET_ET_POL = 7;
   localparam int QET_ET_ECM2 = 6;
   localparam int QET_IN_APOL = 0;
   localparam int QET_IN_BPOL = 1;
   localparam int QET_CH_CLREN = 7;
   localparam int QET_EV_UPD = 0;
   localparam int QET_EV_CC1 = 1;
   localparam int QET_EV_COM = 5;
   localparam int QET_EV_TRG = 6;
   localparam int QET_EV_BRK = 7;

   // slave mode codes
   localparam logic [2:0] QET_SLV_INT = 3'h0;
   localparam logic [2:0] QET_SLV_ENC_B = 3'h1;
   localparam logic [2:0] QET_SLV_ENC_A = 3'h2;
   localparam logic [2:0] QET_SLV_ENC_AB = 3'h3;

   // channel compare modes
   localparam logic [2:0] QET_OC_FROZEN = 3'h0;
   localparam logic [2:0] QET_OC_SET = 3'h1;
   localparam logic [2:0] QET_OC_CLR = 3'h2;
   localparam logic [2:0] QET_OC_TOGGLE = 3'h3;
   localparam logic [2:0] QET_OC_FORCE_LO = 3'h4;
   localparam logic [2:0] QET_OC_FORCE_HI = 3'h5;
   localparam logic [2:0] QET_OC_PWM1 = 3'h6;
   localparam logic [2:0] QET_OC_PWM2 = 3'h7;

   // values after reset, and the count step
   localparam logic [7:0] QET_BYTE_RST = 8'h00;
   localparam logic [15:0] QET_WORD_RST = 16'h0000;
   localparam logic [15:0] QET_RLD_RST = 16'hFFFF;
   localparam logic [15:0] QET_ONE = 16'h0001;

   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } qet_bus_req_t;

   typedef struct packed {
      logic clear_en;
      logic [2:0] mode;
   } qet_chan_cfg_t;
endpackage

// ### verilog/qet_in_filter.sv
// quadrature encoder timer: pin synchroniser, stability filter and polarity
// assumes an asynchronous pin and a level that is stable for filt_len + 1 clocks
`timescale 1ns/1ns
`default_nettype none
module qet_in_filter import qet_pkg::*; #(
   parameter int FW = QET_FILT_W
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic pin,
   input wire logic [FW-1:0] filt_len,
   input wire logic invert,
   output logic level
);
   logic sync1_reg;
   logic sync2_reg;
   logic stable_reg;
   logic [FW-1:0] run_reg;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= pin;
         sync2_reg <= sync1_reg;
      end
   end

   // a new level is taken only after filt_len + 1 agreeing samples
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         stable_reg <= 1'b0;
         run_reg <= '0;
      end else if (sync2_reg == stable_reg) begin
         run_reg <= '0;
      end else if (run_reg >= filt_len) begin
         stable_reg <= sync2_reg;
         run_reg <= '0;
      end else begin
         run_reg <= run_reg + 1'b1;
      end
   end

   assign level = stable_reg ^ invert;
endmodule
`default_nettype wire

// ### verif/qet_timer_properties.sv
// quadrature encoder timer checker: port-level timing relations
// assumes bind onto qet_timer, one clock, resetn active low
`timescale 1ns/1ns
`default_nettype none
module qet_timer_properties import qet_pkg::*; (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire qet_bus_req_t bus_req,
   input wire logic [QET_DW-1:0] rd_data,
   input wire logic encoder_input_a,
   input wire logic encoder_input_b,
   input wire logic ext_trigger_pin,
   input wire logic [QET_NCH-1:0] channel_ref_wave,
   input wire logic dir_flag,
   input wire logic trig_out,
   input wire logic irq_main,
   input wire logic irq_capcomp
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // quiet time counter; 24 covers sync plus the longest filter
   logic [4:0] quiet_reg;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         quiet_reg <= 5'h00;
      else if (bus_req.wr || $changed(encoder_input_a) || $changed(encoder_input_b))
         quiet_reg <= 5'h00;
      else if (quiet_reg != 5'h1F)
         quiet_reg <= quiet_reg + 5'h01;
   end
   sequence s_rld_wr;
      bus_req.wr && bus_req.addr == QET_OFS_RLD_L;
   endsequence
   sequence s_rld_rd;
      bus_req.rd && bus_req.addr == QET_OFS_RLD_L;
   endsequence
   a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
      else $error("read data outside its slot");
   a_unmapped_reads_zero: assert property (bus_req.rd && (bus_req.addr > 5'h18 || bus_req.addr == QET_OFS_EVGEN)
      |=> rd_data == 8'h00) else $error("refused place read nonzero");
   a_reload_read_back: assert property (s_rld_wr ##1 s_rld_rd |=> rd_data == $past(bus_req.wdata, 2))
      else $error("reload byte not read back");
   a_reset_outputs_low: assert property ($rose(resetn) |-> channel_ref_wave == 4'h0 && !irq_main && !irq_capcomp
      && !trig_out && !dir_flag) else $error("output high after reset");
   a_trig_single_pulse: assert property (trig_out |=> !trig_out)
      else $error("trigger output longer than one cycle");
   a_dir_quiet_hold: assert property (quiet_reg >= 5'h18 |-> $stable(dir_flag))
      else $error("direction moved without input edge");
   a_main_fall_write: assert property ($fell(irq_main) |-> $past(bus_req.wr))
      else $error("main request dropped without write");
   a_cc_fall_write: assert property ($fell(irq_capcomp) |-> $past(bus_req.wr))
      else $error("capture request dropped without write");
endmodule
bind qet_timer qet_timer_properties u_props (.clk_sys, .resetn, .bus_req, .rd_data, .encoder_input_a,
   .encoder_input_b, .ext_trigger_pin, .channel_ref_wave, .dir_flag, .trig_out, .irq_main, .irq_capcomp);
`default_nettype wire

// ### verif/qet_encoder_model.sv
// quadrature encoder model: two comparator outputs, one step per request
// assumes the bench holds step_req until it sees step_done high
`timescale 1ns/1ns
`default_nettype none
module qet_encoder_model (
   input wire logic clk_sys,
   input wire logic step_req,
   input wire logic step_back,
   input wire logic [3:0] hold,
   output logic enc_a,
   output logic enc_b,
   output logic step_done
);
   logic [1:0] phase_reg = 2'h0;
   logic [3:0] wait_reg = 4'h0;
   logic busy_reg = 1'b0;
   logic done_reg = 1'b0;
   // gray order: only one line moves per step
   assign enc_a = phase_reg[0] ^ phase_reg[1];
   assign enc_b = phase_reg[1];
   assign step_done = done_reg;
   always @(posedge clk_sys) begin
      if (busy_reg) begin
         wait_reg <= wait_reg + 4'h1;
         // hold spacing lets the filter settle before the next move
         if (wait_reg == hold) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end
      end else if (done_reg) begin
         done_reg <= 1'b0;
      end else if (step_req) begin
         phase_reg <= step_back ? phase_reg - 2'h1 : phase_reg + 2'h1;
         wait_reg <= 4'h0;
         busy_reg <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### verif/qet_timer_test.sv
// quadrature encoder timer testbench: register port, encoder model, trigger pin
// assumes qet_pkg, the encoder model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module qet_timer_test import qet_pkg::*;;
   logic clk_sys = 1'b0, resetn = 1'b0, ext_trigger_pin = 1'b0, step_req = 1'b0, step_back = 1'b0;
   logic [3:0] hold = 4'h5;
   qet_bus_req_t bus_req = '0;
   logic [7:0] rd_data;
   logic [3:0] ref_w;
   logic dir_flag, trig_out, irq_main, irq_capcomp, enc_a, enc_b, step_done, taken = 1'b0, run = 1'b0;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'hAA4488C0;
   logic [1:0] phase = 2'h0, mode = 2'h0;
   logic [15:0] cnt_exp = 16'h0000;
   int num_errors = 0, num_checks = 0;
   qet_timer dut (.clk_sys, .resetn, .bus_req, .rd_data, .encoder_input_a(enc_a), .encoder_input_b(enc_b),
      .ext_trigger_pin, .channel_ref_wave(ref_w), .dir_flag, .trig_out, .irq_main, .irq_capcomp);
   qet_encoder_model enc_model (.clk_sys, .step_req, .step_back, .hold, .enc_a, .enc_b, .step_done);
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      num_checks++;
      if (seen !== expv) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic give_verdict;
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // strobe stays up until the next op or idle, so ops run back to back
   task automatic op(input logic rd, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: rd ? 8'h00 : d, wr: !rd, rd: rd};
      if (rd)
         exp_q.push_back(d);
   endtask
   task automatic idle;
      @(posedge clk_sys);
      bus_req <= '0;
   endtask
   task automatic step(input logic back);
      int i;
      logic a_edge;
      a_edge = !(phase[0] ^ back);
      if (run && (a_edge ? mode[1] : mode[0]))
         cnt_exp = back ? (cnt_exp == 16'h0000 ? 16'h0003 : cnt_exp - 16'h0001)
            : (cnt_exp == 16'h0003 ? 16'h0000 : cnt_exp + 16'h0001);
      @(posedge clk_sys);
      step_back <= back;
      step_req <= 1'b1;
      for (i = 0; i < 40 && step_done !== 1'b1; i++)
         @(posedge clk_sys);
      if (i == 40) begin
         num_errors++;
         give_verdict;
      end
      step_req <= 1'b0;
      phase = back ? phase - 2'h1 : phase + 2'h1;
      @(negedge clk_sys);
      if (run)
         check(dir_flag, back);
   endtask
   always @(posedge clk_sys) taken <= bus_req.rd;
   always @(negedge clk_sys) begin
      if (taken)
         check(rd_data, exp_q.pop_front());
   end
   initial begin
      int i, en, m;
      logic [4:0] a;
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      op(1, QET_OFS_RLD_H, 8'hFF);
      op(1, QET_OFS_CTRL, 8'h00);
      op(1, 5'h1F, 8'h00);
      op(1, QET_OFS_EVGEN, 8'h00);
      for (i = 0; i < 5; i++) begin
         a = i == 2 ? QET_OFS_RLD_L : 5'(QET_OFS_PSC_H + i);
         seed = xs(seed);
         op(0, a, seed[7:0]);
         op(1, a, seed[7:0]);
      end
      op(0, QET_OFS_STATUS, 8'h00);
      for (en = 0; en < 2; en++) begin
         op(0, QET_OFS_IRQEN, en ? 8'hFF : 8'h00);
         for (i = 0; i < 8; i++) begin
            op(0, QET_OFS_EVGEN, 8'h01 << i);
            idle;
            op(1, QET_OFS_STATUS, 8'h01 << i);
            idle;
            @(negedge clk_sys);
            check({irq_main, irq_capcomp}, en ? ((i >= 1 && i <= 4) ? 2'b01 : 2'b10) : 2'b00);
            op(0, QET_OFS_STATUS, 8'h00);
         end
      end
      op(0, QET_OFS_ETCFG, 8'h00);
      op(0, QET_OFS_RLD_H, 8'h00);
      op(0, QET_OFS_RLD_L, 8'h03);
      for (m = 1; m < 4; m++) begin
         op(0, QET_OFS_CNT_H, 8'h00);
         op(0, QET_OFS_CNT_L, 8'h00);
         op(0, QET_OFS_INCFG, m == 3 ? 8'h20 : 8'h00);
         op(0, QET_OFS_SLAVE, 8'(m));
         op(0, QET_OFS_CTRL, 8'h01);
         idle;
         hold <= 4'(5 + m);
         mode = 2'(m);
         run = 1'b1;
         cnt_exp = 16'h0000;
         repeat (6) step(1'b0);
         repeat (3) step(1'b1);
         step(1'b0);
         step(1'b1);
         op(1, QET_OFS_CNT_H, cnt_exp[15:8]);
         op(1, QET_OFS_CNT_L, cnt_exp[7:0]);
         op(0, QET_OFS_CTRL, 8'h00);
         op(1, QET_OFS_CTRL, 8'h10);
         idle;
         run = 1'b0;
         step(1'b0);
         op(1, QET_OFS_CNT_L, cnt_exp[7:0]);
         idle;
      end
      for (i = 0; i < 6; i++)
         op(0, 5'(QET_OFS_CMP0_H + i), 8'hFF);
      op(0, QET_OFS_CHCFG0, 8'h86);
      op(0, 5'(QET_OFS_CHCFG0 + 1), 8'h85);
      op(0, 5'(QET_OFS_CHCFG0 + 2), 8'h06);
      idle;
      repeat (2) @(negedge clk_sys);
      check(ref_w, 4'b0111);
      @(posedge clk_sys) ext_trigger_pin <= 1'b1;
      repeat (8) @(negedge clk_sys);
      check(ref_w, 4'b0110);
      @(posedge clk_sys) ext_trigger_pin <= 1'b0;
      repeat (8) @(negedge clk_sys);
      check(ref_w, 4'b0110);
      op(0, QET_OFS_EVGEN, 8'h01);
      idle;
      @(negedge clk_sys);
      check(trig_out, 1'b1);
      check(ref_w, 4'b0111);
      give_verdict;
   end
endmodule
`default_nettype wire
